//--- core/vscr_regs.sv
// status, control and front end setup registers with the measurement loop sync logic
// How it works
// - loop state field reports idle 0, arm 1, measure 2, trigger 3
// - ready bit sets when power-on reset sequence completes
// - memory size code 0..3 reports 8, 16, 32 or 64 megabytes
// - clock option bit is one when the 10.24 MHz oscillator is fitted
// - sync-effect bit is one once our sync change took effect
// - read-available flag shows at least one data word ready
// - block-available flag shows fifo holds at least a block
// - armed in trigger state, or in arm state with pre-trigger met
// - armed releases sync unless pull_sync_req is high; sync rising moves loop to trigger
// - stopped in idle, or measure after overflow or block-mode end of block
// - stopped releases sync unless pull_sync_req is high; sync rising moves loop to idle
// - overload flag is sticky and cleared by a status read
// - converter fault flag is sticky and cleared by a status read
// - select bit reads zero when module id line is high
// - control bit 0 clears all writable registers except control
// - soft reset zeroes decimation counter and fixes zoom at 0 Hz, fixed phase
// - sysfail inhibit always one; module never drives sysfail
// - wide address enable always reads as zero
// - front end word: range 3-0, dc 4, filter 5, ground 6, input 7
// - each range bit drives one attenuator or gain stage
// - status word bit layout as listed in the package
// - status bit 2 always reads one
`timescale 1ns/100ps
module vscr_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [5:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata_r,
    output logic bus_ack_r,
    input wire logic [1:0] memory_size_code,
    input wire logic osc_option,
    input wire logic module_id,
    input wire vscr_pkg::vscr_acq_s acq,
    input wire logic sync_in,
    input wire logic pull_sync_req,
    input wire logic loop_force_idle,
    input wire logic loop_start_arm,
    output logic sync_oe_r,
    output logic sysfail_oe_r,
    output vscr_pkg::vscr_fe_s fe_r,
    output logic [1:0] loop_state_r,
    output logic soft_reset_r,
    output logic [23:0] decim_count_r,
    output logic [31:0] zoom_freq_r,
    output logic [15:0] zoom_phase_r
);
    // ========================================
    // decode
    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction

    logic rd_status;
    logic wr_control;
    logic wr_front_end;
    assign rd_status = bus_rd && hit(bus_addr, vscr_pkg::OFF_STATUS_CONTROL);
    assign wr_control = bus_wr && hit(bus_addr, vscr_pkg::OFF_STATUS_CONTROL);
    assign wr_front_end = bus_wr && hit(bus_addr, vscr_pkg::OFF_FRONT_END);

    // ========================================
    // power-on sequence
    logic [4:0] por_cnt_r;
    logic ready_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_r <= 5'h00;
            ready_r <= 1'b0;
        end else if (!ready_r) begin
            por_cnt_r <= por_cnt_r + 5'h01;
            if (por_cnt_r == vscr_pkg::POR_LAST) begin
                ready_r <= 1'b1;
            end
        end
    end

    // ========================================
    // control register: only the reset bit is stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_r <= 1'b0;
        end else if (wr_control) begin
            soft_reset_r <= bus_wdata[vscr_pkg::CTL_SOFT_RESET];
        end
    end

    // inhibit bit and wide address bit are ignored on write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sysfail_oe_r <= 1'b0;
        end else begin
            sysfail_oe_r <= 1'b0;
        end
    end

    // ========================================
    // front end setup; held clear while soft reset is high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fe_r <= vscr_pkg::FE_RST;
        end else if (soft_reset_r) begin
            fe_r <= vscr_pkg::FE_RST;
        end else if (wr_front_end) begin
            fe_r.range <= bus_wdata[vscr_pkg::FE_RANGE_LO +: 4];
            fe_r.dc_couple <= bus_wdata[vscr_pkg::FE_DC];
            fe_r.filter_bypass <= bus_wdata[vscr_pkg::FE_FILTER];
            fe_r.ground_barrel <= bus_wdata[vscr_pkg::FE_FLOAT];
            fe_r.input_connector <= bus_wdata[vscr_pkg::FE_INPUT];
        end
    end

    // ========================================
    // decimation counter and zoom oscillator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            decim_count_r <= vscr_pkg::DECIM_ZERO;
            zoom_freq_r <= vscr_pkg::ZOOM_FREQ_ZERO;
            zoom_phase_r <= vscr_pkg::ZOOM_PHASE_FIXED;
        end else if (soft_reset_r) begin
            decim_count_r <= vscr_pkg::DECIM_ZERO;
            zoom_freq_r <= vscr_pkg::ZOOM_FREQ_ZERO;
            zoom_phase_r <= vscr_pkg::ZOOM_PHASE_FIXED;
        end else begin
            decim_count_r <= decim_count_r + 24'h000001;
            zoom_phase_r <= zoom_phase_r + zoom_freq_r[31:16];
        end
    end

    // ========================================
    // measurement loop
    logic sync_prev_r;
    logic sync_rise;
    logic armed;
    logic stopped;
    assign sync_rise = sync_in && !sync_prev_r;
    assign armed = (loop_state_r == vscr_pkg::VSCR_TRIGGER) ||
                   ((loop_state_r == vscr_pkg::VSCR_ARM) && acq.pretrig_met);
    assign stopped = (loop_state_r == vscr_pkg::VSCR_IDLE) ||
                     ((loop_state_r == vscr_pkg::VSCR_MEASURE) &&
                      (acq.fifo_overflow || (acq.block_mode && acq.end_of_block)));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // the line idles high on its pull-up; a reset value of one keeps a false rise away
            sync_prev_r <= 1'b1;
        end else begin
            sync_prev_r <= sync_in;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loop_state_r <= vscr_pkg::VSCR_IDLE;
        end else if (soft_reset_r || loop_force_idle) begin
            loop_state_r <= vscr_pkg::VSCR_IDLE;
        end else begin
            case (loop_state_r)
                vscr_pkg::VSCR_IDLE: begin
                    if (loop_start_arm) begin
                        loop_state_r <= vscr_pkg::VSCR_ARM;
                    end
                end
                vscr_pkg::VSCR_ARM: begin
                    if (sync_rise && armed) begin
                        loop_state_r <= vscr_pkg::VSCR_TRIGGER;
                    end
                end
                vscr_pkg::VSCR_TRIGGER: begin
                    if (!sync_in && sync_prev_r) begin
                        loop_state_r <= vscr_pkg::VSCR_MEASURE;
                    end
                end
                vscr_pkg::VSCR_MEASURE: begin
                    if (sync_rise && stopped) begin
                        loop_state_r <= vscr_pkg::VSCR_IDLE;
                    end
                end
                default: begin
                    loop_state_r <= vscr_pkg::VSCR_IDLE;
                end
            endcase
        end
    end

    // sync is pulled low unless our condition asks for release
    logic release_sync;
    assign release_sync = !pull_sync_req && (armed || stopped);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_oe_r <= 1'b0;
        end else begin
            sync_oe_r <= !release_sync;
        end
    end

    // effect seen: the line matches what we asked for
    logic sync_effect;
    assign sync_effect = (sync_oe_r == !sync_in);

    // ========================================
    // sticky flags; set wins over the read clear
    logic overload_r;
    logic fault_r;
    vscr_sticky u_overload (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(acq.overload_evt),
        .clear_in(rd_status),
        .flag_r(overload_r)
    );
    vscr_sticky u_fault (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(acq.fault_evt),
        .clear_in(rd_status),
        .flag_r(fault_r)
    );

    // ========================================
    // status word assembly
    logic [15:0] status_word;
    always_comb begin
        status_word = vscr_pkg::RST_WORD;
        status_word[vscr_pkg::STS_LOOP_LO +: 2] = loop_state_r;
        status_word[vscr_pkg::STS_PASSED] = 1'b1;
        status_word[vscr_pkg::STS_READY] = ready_r;
        status_word[vscr_pkg::STS_MEM_LO +: 2] = memory_size_code;
        status_word[vscr_pkg::STS_CLKOPT] = osc_option;
        status_word[vscr_pkg::STS_SYNC_EFFECT] = sync_effect;
        status_word[vscr_pkg::STS_READ_AVAIL] = acq.word_avail;
        status_word[vscr_pkg::STS_BLOCK_AVAIL] = acq.block_avail;
        status_word[vscr_pkg::STS_ARMED] = armed;
        status_word[vscr_pkg::STS_STOPPED] = stopped;
        status_word[vscr_pkg::STS_OVERLOAD] = overload_r;
        status_word[vscr_pkg::STS_CONV_FAULT] = fault_r;
        status_word[vscr_pkg::STS_NOT_SELECTED] = !module_id;
        status_word[vscr_pkg::STS_WIDE_ADDR] = 1'b0;
    end

    // unlabelled addresses give no ack, so the access is not answered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_r <= vscr_pkg::RST_WORD;
            bus_ack_r <= 1'b0;
        end else begin
            bus_rdata_r <= rd_status ? status_word : vscr_pkg::RST_WORD;
            bus_ack_r <= rd_status || wr_control || wr_front_end;
        end
    end

    // ========================================
    // checks
    sequence s_status_read;
        bus_rd && (bus_addr == vscr_pkg::OFF_STATUS_CONTROL);
    endsequence

    sequence s_stop_rise;
        loop_state_r == vscr_pkg::VSCR_MEASURE && stopped && sync_rise && !soft_reset_r && !loop_force_idle;
    endsequence

    a_passed_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read |=> bus_rdata_r[vscr_pkg::STS_PASSED])
        else $error("passed bit not one");
    a_loop_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read |=> bus_rdata_r[1:0] == $past(loop_state_r))
        else $error("loop field wrong");
    a_overload_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read ##0 !acq.overload_evt |=> !overload_r)
        else $error("overload not cleared");
    a_fault_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acq.fault_evt |=> fault_r)
        else $error("fault event lost");
    a_wide_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read |=> !bus_rdata_r[vscr_pkg::STS_WIDE_ADDR])
        else $error("wide address bit set");
    a_sysfail_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sysfail_oe_r)
        else $error("sysfail driven");
    a_soft_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset_r |=> fe_r == vscr_pkg::FE_RST && decim_count_r == vscr_pkg::DECIM_ZERO
            && zoom_phase_r == vscr_pkg::ZOOM_PHASE_FIXED)
        else $error("soft reset did not clear");
    a_ready_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ready_r) |-> $past(por_cnt_r) == vscr_pkg::POR_LAST)
        else $error("ready too early");
    a_trig_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loop_state_r == vscr_pkg::VSCR_ARM && armed && sync_rise && !soft_reset_r && !loop_force_idle
            |=> loop_state_r == vscr_pkg::VSCR_TRIGGER)
        else $error("no trigger entry");
    a_release_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stopped && !pull_sync_req |=> !sync_oe_r)
        else $error("sync held while stopped");
    a_idle_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_stop_rise |=> loop_state_r == vscr_pkg::VSCR_IDLE)
        else $error("no idle entry");
    a_overflow_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read ##0 (loop_state_r == vscr_pkg::VSCR_MEASURE && acq.fifo_overflow)
            |=> bus_rdata_r[vscr_pkg::STS_STOPPED])
        else $error("overflow did not stop collection");
    a_select_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read |=> bus_rdata_r[vscr_pkg::STS_NOT_SELECTED] == !$past(module_id))
        else $error("select bit wrong");
    a_effect_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_status_read |=> bus_rdata_r[vscr_pkg::STS_SYNC_EFFECT] == ($past(sync_oe_r) != $past(sync_in)))
        else $error("sync effect bit wrong");
endmodule

//--- core/vscr_sticky.sv
// sticky event flag, cleared by a read, set winning over clear
`timescale 1ns/100ps
module vscr_sticky (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic clear_in,
    output logic flag_r
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (event_in) begin
            flag_r <= 1'b1;
        end else if (clear_in) begin
            flag_r <= 1'b0;
        end
    end
endmodule

//--- include/vscr_pkg.sv
// package: register map, field layout and carriers for the digitizer status/control registers
package vscr_pkg;
    // ========================================
    // register offsets (byte addresses, A16 window)
    localparam logic [5:0] OFF_STATUS_CONTROL = 6'h04;
    localparam logic [5:0] OFF_FRONT_END = 6'h06;

    // ========================================
    // status word field positions
    localparam int STS_LOOP_LO = 0;
    localparam int STS_PASSED = 2;
    localparam int STS_READY = 3;
    localparam int STS_MEM_LO = 4;
    localparam int STS_CLKOPT = 6;
    localparam int STS_SYNC_EFFECT = 7;
    localparam int STS_READ_AVAIL = 8;
    localparam int STS_BLOCK_AVAIL = 9;
    localparam int STS_ARMED = 10;
    localparam int STS_STOPPED = 11;
    localparam int STS_OVERLOAD = 12;
    localparam int STS_CONV_FAULT = 13;
    localparam int STS_NOT_SELECTED = 14;
    localparam int STS_WIDE_ADDR = 15;

    // ========================================
    // control word bits
    localparam int CTL_SOFT_RESET = 0;
    localparam int CTL_SYSFAIL_INHIBIT = 1;
    localparam int CTL_WIDE_ADDR = 15;

    // ========================================
    // front end setup fields
    localparam int FE_RANGE_LO = 0;
    localparam int FE_DC = 4;
    localparam int FE_FILTER = 5;
    localparam int FE_FLOAT = 6;
    localparam int FE_INPUT = 7;

    // ========================================
    // reset values and timing
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] FE_RST = 8'h00;
    localparam int POR_CYCLES = 16;
    localparam logic [4:0] POR_LAST = 5'(POR_CYCLES - 1);
    localparam logic [23:0] DECIM_ZERO = 24'h000000;
    localparam logic [31:0] ZOOM_FREQ_ZERO = 32'h00000000;
    // 54.77461 deg as a 16-bit phase word: 54.77461/360*65536 = 9971.4
    localparam logic [15:0] ZOOM_PHASE_FIXED = 16'h26F3;

    typedef enum logic [1:0] {
        VSCR_IDLE = 2'b00,
        VSCR_ARM = 2'b01,
        VSCR_MEASURE = 2'b10,
        VSCR_TRIGGER = 2'b11
    } vscr_loop_e;

    // conditions fed in by the acquisition path
    typedef struct packed {
        logic pretrig_met;
        logic fifo_overflow;
        logic end_of_block;
        logic block_mode;
        logic word_avail;
        logic block_avail;
        logic overload_evt;
        logic fault_evt;
    } vscr_acq_s;

    // analog front end controls
    typedef struct packed {
        logic [3:0] range;
        logic dc_couple;
        logic filter_bypass;
        logic ground_barrel;
        logic input_connector;
    } vscr_fe_s;
endpackage

//--- test/vscr_sync_peer.sv
// far side model: peer modules sharing the open-drain sync line with the block
`timescale 1ns/100ps
module vscr_sync_peer (
    input wire logic dut_pull,
    input wire logic peer_pull,
    output logic sync_line
);
    // ========================================
    // wired line
    // the line has a pull-up, so it rises only once every module has let go
    assign sync_line = !(dut_pull || peer_pull);
endmodule

//--- test/vxi_adc_status_control_regs_tb.sv
// self-checking bench for the status, control and front end setup registers
`timescale 1ns/100ps
module vxi_adc_status_control_regs_tb;
    localparam logic [5:0] A_ST = vscr_pkg::OFF_STATUS_CONTROL;
    localparam logic [5:0] A_FE = vscr_pkg::OFF_FRONT_END;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] bus_addr = 6'h00;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [1:0] memory_size_code = 2'h0;
    logic osc_option = 1'b0;
    logic module_id = 1'b0;
    vscr_pkg::vscr_acq_s acq = '0;
    logic pull_sync_req = 1'b0;
    logic loop_start_arm = 1'b0;
    logic peer_pull = 1'b0;
    logic sync_in;
    logic [15:0] bus_rdata_r;
    logic bus_ack_r;
    logic sync_oe_r;
    logic sysfail_oe_r;
    vscr_pkg::vscr_fe_s fe_r;
    logic [1:0] loop_state_r;
    logic soft_reset_r;
    logic [23:0] decim_count_r;
    logic [31:0] zoom_freq_r;
    logic [15:0] zoom_phase_r;
    int err_total = 0;
    int checked = 0;

    always #12.5 clk_sys = ~clk_sys;

    vscr_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r), .bus_ack_r(bus_ack_r),
        .memory_size_code(memory_size_code), .osc_option(osc_option), .module_id(module_id), .acq(acq),
        .sync_in(sync_in), .pull_sync_req(pull_sync_req), .loop_force_idle(1'b0),
        .loop_start_arm(loop_start_arm), .sync_oe_r(sync_oe_r), .sysfail_oe_r(sysfail_oe_r), .fe_r(fe_r),
        .loop_state_r(loop_state_r), .soft_reset_r(soft_reset_r), .decim_count_r(decim_count_r),
        .zoom_freq_r(zoom_freq_r), .zoom_phase_r(zoom_phase_r));

    vscr_sync_peer peer_u (.dut_pull(sync_oe_r), .peer_pull(peer_pull), .sync_line(sync_in));

    // ========================================
    // shared tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // a read may carry a same-cycle overload and fault event
    task automatic rd(input logic [5:0] a, input logic ev, output logic [15:0] d, output logic k);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        acq.overload_evt <= ev;
        acq.fault_evt <= ev;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        acq.overload_evt <= 1'b0;
        acq.fault_evt <= 1'b0;
        #1;
        d = bus_rdata_r;
        k = bus_ack_r;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] w, output logic k);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= w;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        #1;
        k = bus_ack_r;
    endtask

    function automatic vscr_pkg::vscr_fe_s fe_of(input logic [15:0] w);
        vscr_pkg::vscr_fe_s e;
        e.range = w[3:0];
        e.dc_couple = w[4];
        e.filter_bypass = w[5];
        e.ground_barrel = w[6];
        e.input_connector = w[7];
        return e;
    endfunction

    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        while (loop_state_r !== s && n < 64) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (loop_state_r !== s) begin
            check(loop_state_r, s);
            close_out;
        end
    endtask

    // ========================================
    // scenarios
    task automatic t_ident;
        logic [15:0] d;
        logic k;
        rd(A_ST, 1'b0, d, k);
        check(d[3], 1'b0);
        repeat (vscr_pkg::POR_CYCLES) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            memory_size_code <= 2'(i);
            osc_option <= i[0];
            module_id <= i[1];
            acq.word_avail <= i[0];
            acq.block_avail <= i[1];
            rd(A_ST, 1'b0, d, k);
            check(k, 1'b1);
            check(d[1:0], vscr_pkg::VSCR_IDLE);
            check(d[2], 1'b1);
            check(d[3], 1'b1);
            check(d[5:4], i[1:0]);
            check(d[6], i[0]);
            check(d[7], 1'b1);
            check(d[8], i[0]);
            check(d[9], i[1]);
            check(d[11], 1'b1);
            check(d[14], !i[1]);
        end
        $display("test ident finished");
    endtask

    task automatic t_sticky;
        logic [15:0] d;
        logic k;
        @(posedge clk_sys);
        acq.overload_evt <= 1'b1;
        @(posedge clk_sys);
        acq.overload_evt <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(A_ST, 1'b0, d, k);
        check(d[13:12], 2'h1);
        rd(A_ST, 1'b1, d, k);
        check(d[13:12], 2'h0);
        rd(A_ST, 1'b0, d, k);
        check(d[13:12], 2'h3);
        rd(A_ST, 1'b0, d, k);
        check(d[13:12], 2'h0);
        $display("test sticky finished");
    endtask

    task automatic t_soft;
        logic [15:0] d;
        logic k;
        wr(A_FE, 16'hFF5A, k);
        @(posedge clk_sys);
        #1;
        check(fe_r, fe_of(16'hFF5A));
        wr(A_ST, 16'h8003, k);
        check(k, 1'b1);
        @(posedge clk_sys);
        #1;
        check(soft_reset_r, 1'b1);
        check(fe_r, 8'h00);
        check(decim_count_r, 24'h000000);
        check(zoom_freq_r, 32'h00000000);
        check(zoom_phase_r, vscr_pkg::ZOOM_PHASE_FIXED);
        check(sysfail_oe_r, 1'b0);
        rd(A_ST, 1'b0, d, k);
        check(d[15], 1'b0);
        // programming is locked out while the soft reset bit is held
        wr(A_FE, 16'h00FF, k);
        @(posedge clk_sys);
        #1;
        check(fe_r, 8'h00);
        check(decim_count_r, 24'h000000);
        wr(A_ST, 16'h0000, k);
        // no converter is modelled, so the calibration hold after soft reset is left to the controller
        wr(A_FE, 16'h00A5, k);
        @(posedge clk_sys);
        #1;
        check(fe_r, fe_of(16'h00A5));
        wr(6'h08, 16'h0003, k);
        check(k, 1'b0);
        rd(A_FE, 1'b0, d, k);
        check(k, 1'b0);
        check(fe_r, fe_of(16'h00A5));
        $display("test soft reset finished");
    endtask

    task automatic t_loop;
        logic [15:0] d;
        logic k;
        @(posedge clk_sys);
        peer_pull <= 1'b1;
        loop_start_arm <= 1'b1;
        @(posedge clk_sys);
        loop_start_arm <= 1'b0;
        wait_state(vscr_pkg::VSCR_ARM);
        check(loop_state_r, vscr_pkg::VSCR_ARM);
        check(sync_oe_r, 1'b1);
        @(posedge clk_sys);
        acq.pretrig_met <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(A_ST, 1'b0, d, k);
        check(d[10], 1'b1);
        check(d[1:0], vscr_pkg::VSCR_ARM);
        check(d[7], 1'b0);
        check(sync_oe_r, 1'b0);
        @(posedge clk_sys);
        peer_pull <= 1'b0;
        wait_state(vscr_pkg::VSCR_TRIGGER);
        check(loop_state_r, vscr_pkg::VSCR_TRIGGER);
        @(posedge clk_sys);
        acq.pretrig_met <= 1'b0;
        rd(A_ST, 1'b0, d, k);
        check(d[10], 1'b1);
        check(d[7], 1'b1);
        @(posedge clk_sys);
        pull_sync_req <= 1'b1;
        wait_state(vscr_pkg::VSCR_MEASURE);
        check(loop_state_r, vscr_pkg::VSCR_MEASURE);
        @(posedge clk_sys);
        pull_sync_req <= 1'b0;
        acq.end_of_block <= 1'b1;
        repeat (6) @(posedge clk_sys);
        // end of block alone must not halt collection outside block mode
        rd(A_ST, 1'b0, d, k);
        check(d[11], 1'b0);
        check(loop_state_r, vscr_pkg::VSCR_MEASURE);
        check(sync_oe_r, 1'b1);
        // a peer holding the line low keeps the loop in measure while overflow halts collection
        @(posedge clk_sys);
        peer_pull <= 1'b1;
        acq.fifo_overflow <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(A_ST, 1'b0, d, k);
        check(d[11], 1'b1);
        check(d[1:0], vscr_pkg::VSCR_MEASURE);
        check(sync_oe_r, 1'b0);
        @(posedge clk_sys);
        peer_pull <= 1'b0;
        acq.fifo_overflow <= 1'b0;
        acq.block_mode <= 1'b1;
        wait_state(vscr_pkg::VSCR_IDLE);
        check(loop_state_r, vscr_pkg::VSCR_IDLE);
        @(posedge clk_sys);
        acq.end_of_block <= 1'b0;
        acq.block_mode <= 1'b0;
        rd(A_ST, 1'b0, d, k);
        check(d[11], 1'b1);
        $display("test loop finished");
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_ident();
        t_sticky();
        t_soft();
        t_loop();
        close_out();
    end
endmodule
